/* watchdog_seven_bit_timer.sv */
// Watchdog with 7-bit counter, interval timer time base and RC source
`timescale 1ns/1ps
module watchdog_seven_bit_timer #(
  parameter int CNT_W = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Device state inputs (asynchronous pins/clocks)
  input wire logic stop_mode,
  input wire logic sub_clock_mode,
  input wire logic rc_osc_tick,
  // Outputs to CPU core
  output logic wdt_reset_n,
  output logic main_osc_on,
  output logic irq
);
  // Synchronisers for asynchronous inputs
  logic [1:0] stop_sync;
  logic [1:0] sub_sync;
  logic [1:0] rc_sync;
  logic rc_prev; // Edge detector reads second stage only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stop_sync <= 2'h0;
      sub_sync <= 2'h0;
      rc_sync <= 2'h0;
      rc_prev <= 1'b0;
    end else begin
      stop_sync <= {stop_sync[0], stop_mode};
      sub_sync <= {sub_sync[0], sub_clock_mode};
      rc_sync <= {rc_sync[0], rc_osc_tick};
      rc_prev <= rc_sync[1];
    end
  end
  logic stop_s;
  logic sub_s;
  logic rc_edge;
  assign stop_s = stop_sync[1];
  assign sub_s = sub_sync[1];
  assign rc_edge = rc_sync[1] & ~rc_prev;

  // Registers
  logic [7:0] clock_control_register; // Write-only, shares ADDR_CTRL
  logic [7:0] watchdog_compare;
  logic [wdt_pkg::STAT_W-1:0] status; // Sticky events
  logic [wdt_pkg::STAT_W-1:0] mask;
  logic [7:0] interval_timer_count;
  logic [CNT_W-1:0] wdt_count;
  logic watchdog_reset_select;
  logic rc_clock_select;
  assign watchdog_reset_select =
    clock_control_register[wdt_pkg::RESET_SEL_BIT];
  assign rc_clock_select = clock_control_register[wdt_pkg::RC_SEL_BIT];

  // Bus strobes: writes take effect at once; a read holds one wait
  // state so that the registered read data stand when it completes
  logic wr_ctrl;
  logic wr_cmp;
  logic wr_mask;
  logic rd_stat;
  logic rd_first; // First cycle of a read: capture data, stall master
  logic rd_done; // Read data captured, the next edge ends the read
  assign rd_first = read && !rd_done;
  assign waitrequest = rd_first;
  assign wr_ctrl = write && address == wdt_pkg::ADDR_CTRL;
  assign wr_cmp = write && address == wdt_pkg::ADDR_CMP;
  assign wr_mask = write && address == wdt_pkg::ADDR_MASK;
  // Read-clear acts only at the edge that completes the read
  assign rd_stat = read && rd_done && address == wdt_pkg::ADDR_STAT;
  // Wait-state flag; a new read always starts with a capture cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_done <= 1'b0;
    end else begin
      rd_done <= rd_first;
    end
  end

  // Clock control register; interval clear bit self-clears next cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clock_control_register <= wdt_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      clock_control_register <= writedata[7:0];
    end else begin
      clock_control_register[wdt_pkg::BIT_CLEAR_BIT] <= 1'b0;
    end
  end

  // Compare register; counter-clear bit lasts one cycle only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      watchdog_compare <= wdt_pkg::CMP_RESET;
    end else if (wr_cmp) begin
      watchdog_compare <= writedata[7:0];
    end else begin
      watchdog_compare[wdt_pkg::COUNTER_CLEAR_BIT] <= 1'b0;
    end
  end
  logic counter_clear;
  assign counter_clear = watchdog_compare[wdt_pkg::COUNTER_CLEAR_BIT];

  // Stop mode halts the system path, but not the RC path
  logic run_sys;
  assign run_sys = ~stop_s;

  // Prescaler of the interval timer: divide by 8..1024
  logic [wdt_pkg::PRESCALE_W-1:0] prescale;
  logic [2:0] pre_sel;
  logic pre_tick;
  assign pre_sel = clock_control_register[2:0];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prescale <= '0;
    end else if (clock_control_register[wdt_pkg::BIT_CLEAR_BIT]) begin
      // Restart the prescale too, so a cleared interval timer begins
      // a whole prescale period and not a part of one
      prescale <= '0;
    end else if (run_sys) begin
      prescale <= prescale + 1'b1;
    end
  end
  // Tick when the selected bit wraps
  logic [wdt_pkg::PRESCALE_W-1:0] pre_lim;
  assign pre_lim = wdt_pkg::PRESCALE_W'((1 << (pre_sel +
    wdt_pkg::PRESCALE_BASE)) - 1);
  assign pre_tick = run_sys &&
    ((prescale & pre_lim) == pre_lim);

  // Interval timer: RC ticks when RC selected, else prescaled clock
  logic bit_tick;
  logic bit_overflow;
  logic bit_cleared; // Watchdog waits for an interval timer clear
  assign bit_tick = rc_clock_select ? rc_edge : pre_tick;
  assign bit_overflow = bit_tick && interval_timer_count == 8'hFF;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      interval_timer_count <= 8'h00;
    end else if (clock_control_register[wdt_pkg::BIT_CLEAR_BIT]) begin
      interval_timer_count <= 8'h00;
    end else if (bit_tick) begin
      interval_timer_count <= interval_timer_count + 1'b1;
    end
  end

  // Gate: in reset mode, watchdog counter enabled only after interval timer clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bit_cleared <= 1'b0;
    end else if (wr_ctrl && writedata[wdt_pkg::RESET_SEL_BIT] &&
                 !watchdog_reset_select) begin
      // Turning reset mode on stops counting until the next clear
      bit_cleared <= 1'b0;
    end else if (!watchdog_reset_select) begin
      // Plain timer mode counts freely
      bit_cleared <= 1'b1;
    end else if (clock_control_register[wdt_pkg::BIT_CLEAR_BIT]) begin
      bit_cleared <= 1'b1;
    end
  end

  // Watchdog counter: advances per interval timer overflow
  logic match;
  logic wdt_fire;
  assign match = wdt_count == watchdog_compare[CNT_W-1:0];
  // RC path adds half an interval via the half-way tick of the timer
  logic rc_half_tick;
  assign rc_half_tick = rc_clock_select && bit_tick &&
    interval_timer_count == (wdt_pkg::RC_HALF - 8'h01);
  assign wdt_fire = bit_cleared && match &&
    (rc_clock_select ? rc_half_tick : bit_overflow);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wdt_count <= '0;
    end else if (counter_clear || wdt_fire) begin
      wdt_count <= '0;
    end else if (bit_cleared && bit_overflow) begin
      wdt_count <= wdt_count + 1'b1;
    end
  end

  // Reset pulse towards the core, stretched for a few cycles
  logic [2:0] rst_cnt;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rst_cnt <= 3'h0;
    end else if (wdt_fire && watchdog_reset_select) begin
      rst_cnt <= 3'(wdt_pkg::RESET_PULSE_CYC);
    end else if (rst_cnt != 3'h0) begin
      rst_cnt <= rst_cnt - 3'h1;
    end
  end
  assign wdt_reset_n = (rst_cnt == 3'h0);

  // Main oscillator: off in sub clock mode, but a watchdog reset there
  // turns it back on and keeps it on until software leaves sub mode,
  // so the core restarts on the fast clock
  logic osc_restart; // Latched restart after a sub mode reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_restart <= 1'b0;
    end else if (wdt_fire && watchdog_reset_select && sub_s) begin
      osc_restart <= 1'b1;
    end else if (!sub_s) begin
      osc_restart <= 1'b0;
    end
  end
  // Oscillator enable output
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      main_osc_on <= 1'b1;
    end else if (wdt_fire && watchdog_reset_select && sub_s) begin
      main_osc_on <= 1'b1;
    end else begin
      main_osc_on <= ~sub_s | osc_restart;
    end
  end

  // Sticky status: set wins over read-clear
  logic [wdt_pkg::STAT_W-1:0] events;
  logic [wdt_pkg::STAT_W-1:0] reported; // Bits the pending read returned
  assign reported = readdata[wdt_pkg::STAT_W-1:0];
  assign events[wdt_pkg::STAT_WDT] =
    wdt_fire && !watchdog_reset_select;
  assign events[wdt_pkg::STAT_BIT] = bit_overflow;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status <= '0;
    end else begin
      // Clear only what the read reported; later events stay pending
      status <= (status & ~(rd_stat ? reported : '0)) | events;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask <= '0;
    end else if (wr_mask) begin
      mask <= writedata[wdt_pkg::STAT_W-1:0];
    end
  end
  assign irq = |(status & mask);
  logic watchdog_interrupt_flag;
  assign watchdog_interrupt_flag = status[wdt_pkg::STAT_WDT];

  // Read data registered; control address reads interval count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      readdata <= 32'h0;
    end else if (rd_first) begin
      unique case (address)
        wdt_pkg::ADDR_CTRL: readdata <= {24'h0, interval_timer_count};
        wdt_pkg::ADDR_CMP: readdata <= {24'h0, watchdog_compare};
        wdt_pkg::ADDR_STAT: readdata <= {30'h0, status};
        wdt_pkg::ADDR_MASK: readdata <= {30'h0, mask};
        wdt_pkg::ADDR_CNT: readdata <= {25'h0, wdt_count};
        default: readdata <= 32'h0;
      endcase
    end
  end

  // Assertions
  // Setting the counter-clear bit shows in the register next cycle
  a_clear_bit_self: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_cmp && writedata[wdt_pkg::COUNTER_CLEAR_BIT] |=> counter_clear)
    else $error("clear bit not set");
  // A pending clear empties the counter
  a_clear_counter: assert property (
    @(posedge clk) disable iff (!rst_n)
    counter_clear |=> wdt_count == '0)
    else $error("counter not clear");
  // The clear bit drops by itself after one cycle
  a_clear_lasts_one: assert property (
    @(posedge clk) disable iff (!rst_n)
    counter_clear && !wr_cmp |=> !counter_clear)
    else $error("clear bit stuck");
  // Reset mode: a match pulls the reset line low
  a_fire_reset: assert property (
    @(posedge clk) disable iff (!rst_n)
    wdt_fire && watchdog_reset_select |=> !wdt_reset_n)
    else $error("no reset");
  // Timer mode: a match sets the interrupt flag instead
  a_fire_irq_flag: assert property (
    @(posedge clk) disable iff (!rst_n)
    wdt_fire && !watchdog_reset_select |=> watchdog_interrupt_flag)
    else $error("no flag");
  // An unmasked watchdog event raises the interrupt line
  a_irq_unmasked: assert property (
    @(posedge clk) disable iff (!rst_n)
    events[wdt_pkg::STAT_WDT] && mask[wdt_pkg::STAT_WDT] && !wr_mask |=>
    irq) else $error("no irq");
  // System path count freezes in stop mode
  a_stop_holds: assert property (
    @(posedge clk) disable iff (!rst_n)
    stop_s && !rc_clock_select && !counter_clear |=> $stable(wdt_count))
    else $error("count moved in stop");
  // Turning on reset mode closes the counting gate
  a_gate_on_select: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_ctrl && writedata[wdt_pkg::RESET_SEL_BIT] && !watchdog_reset_select
    |=> !bit_cleared) else $error("gate open after select");
  // With the gate closed the counter does not advance
  a_gate_before_clear: assert property (
    @(posedge clk) disable iff (!rst_n)
    !bit_cleared |=> wdt_count == $past(wdt_count) || counter_clear ||
    $past(counter_clear)) else $error("counted before clear");
  // A match restarts the counter from zero
  a_fire_clears: assert property (
    @(posedge clk) disable iff (!rst_n)
    wdt_fire && !counter_clear |=> wdt_count == '0)
    else $error("no clear after match");
  // A reset in sub clock mode turns the main oscillator on
  a_osc_on_reset: assert property (
    @(posedge clk) disable iff (!rst_n)
    wdt_fire && watchdog_reset_select && sub_s |=> main_osc_on)
    else $error("osc off");
  // And it stays on while the core is still in sub mode
  a_osc_held: assert property (
    @(posedge clk) disable iff (!rst_n)
    osc_restart && sub_s |=> main_osc_on)
    else $error("osc dropped");
  // A read stalls exactly one cycle, then completes
  a_read_one_wait: assert property (
    @(posedge clk) disable iff (!rst_n)
    rd_first |=> !waitrequest)
    else $error("read wait too long");
  // Reset leaves the watchdog reset function off
  a_sel_reset_zero: assert property (
    @(posedge clk)
    !rst_n |=> !watchdog_reset_select)
    else $error("select not zero");
endmodule

/* wdt_pkg.sv */
// Package: register map, field positions and reset values of the watchdog
package wdt_pkg;
  // Avalon-MM word offsets (byte address = 4 * index)
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CMP = 4'h1;
  localparam logic [3:0] ADDR_STAT = 4'h2;
  localparam logic [3:0] ADDR_MASK = 4'h3;
  localparam logic [3:0] ADDR_CNT = 4'h4;
  // Clock control fields
  localparam int PRESCALE_LSB = 0;
  localparam int RESET_SEL_BIT = 4;
  localparam int RC_SEL_BIT = 5;
  localparam int BIT_CLEAR_BIT = 6;
  // Compare register fields
  localparam int COUNTER_CLEAR_BIT = 7;
  // Status bits
  localparam int STAT_WDT = 0;
  localparam int STAT_BIT = 1;
  localparam int STAT_W = 2;
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CMP_RESET = 8'h00;
  // Prescaler: least divide is 8 -> shift base 3
  localparam int PRESCALE_BASE = 3;
  localparam int PRESCALE_W = 11;
  // RC half-interval, in RC ticks: 2^8 / 2
  localparam int RC_TICKS_W = 8;
  localparam logic [7:0] RC_HALF = 8'h80;
  // Watchdog reset pulse length towards the core, in clock cycles
  localparam int RESET_PULSE_CYC = 4;
endpackage

/* cpu_core_model.sv */
// CPU core side model: counts and measures watchdog reset pulses
`timescale 1ns/1ps
module cpu_core_model (
  // Clock
  input wire logic clk,
  // Reset request from the watchdog
  input wire logic wdt_reset_n,
  // Pulse statistics
  output int pulses,
  output int width
);
  int run = 0; // Length of the pulse in progress
  initial pulses = 0;
  initial width = 0;
  // The core sits in reset while the line is low; log each whole pulse
  always @(posedge clk) begin
    if (wdt_reset_n === 1'b0) begin
      run <= run + 1;
    end else if (run > 0) begin
      pulses <= pulses + 1;
      width <= run;
      run <= 0;
    end
  end
endmodule

/* test_watchdog_seven_bit_timer.sv */
// Self-checking bench: bus, interrupt, reset, stop and RC source paths
`timescale 1ns/1ps
module test_watchdog_seven_bit_timer;
  // Bus and device inputs
  logic clk = 0;
  logic rst_n = 0;
  logic [3:0] address = 4'h0;
  logic read = 0;
  logic write = 0;
  logic [31:0] writedata = 32'h0;
  logic stop_mode = 0;
  logic sub_clock_mode = 0;
  logic rc_osc_tick = 0;
  // Design outputs
  logic [31:0] readdata;
  logic waitrequest, wdt_reset_n, main_osc_on, irq;
  // Bench state
  int pulses, width, n, n_fail = 0, n_tests = 0;
  logic [31:0] v, a;

  always #2 clk = ~clk;
  // RC source runs free, 20 cycles a tick, never on a rising clock edge
  always #40 rc_osc_tick = ~rc_osc_tick;

  watchdog_seven_bit_timer watchdog_seven_bit_timer_inst (.clk, .rst_n,
    .address, .read, .write, .writedata, .readdata, .waitrequest,
    .stop_mode, .sub_clock_mode, .rc_osc_tick, .wdt_reset_n,
    .main_osc_on, .irq);
  cpu_core_model cpu_core_model_inst (.clk, .wdt_reset_n, .pulses, .width);

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %0h seen %0h", s, e, g);
    end
  endtask
  // Bus write: the request stands until waitrequest is seen low
  task wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clk);
    address <= ad;
    writedata <= {24'h0, d};
    write <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask
  // Bus read: data is taken at the edge where waitrequest is seen low
  task rd(input logic [3:0] ad, output logic [31:0] d);
    @(posedge clk);
    address <= ad;
    read <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
  endtask
  task wait_irq;
    n = 0;
    while (irq !== 1'b1 && n < 14000) begin
      @(posedge clk);
      n++;
    end
  endtask
  // Reset, read-only and unmapped places, no watchdog reset after reset
  task t_defaults;
    a = pulses;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("irq", 0, irq);
    chk("osc", 1, main_osc_on);
    wr(wdt_pkg::ADDR_STAT, 8'hFF);
    rd(wdt_pkg::ADDR_STAT, v);
    chk("stat_ro", 0, v);
    rd(4'hF, v);
    chk("unmapped", 0, v);
    wr(wdt_pkg::ADDR_CTRL, 8'h40);
    rd(wdt_pkg::ADDR_CTRL, v);
    chk("interval_timer_count", 0, v);
    repeat (5000) @(posedge clk);
    chk("pulses", a, pulses);
  endtask
  // Interrupt mode: match after compare+1 overflows, read clears
  task t_irq;
    rd(wdt_pkg::ADDR_STAT, v); // drop events of earlier tests
    wr(wdt_pkg::ADDR_MASK, 8'h01);
    wr(wdt_pkg::ADDR_CMP, 8'h81);
    rd(wdt_pkg::ADDR_CMP, v);
    chk("cmp", 1, v);
    wr(wdt_pkg::ADDR_CTRL, 8'h40);
    wait_irq();
    chk("irq_time", 1, n >= 4080 && n <= 6160);
    rd(wdt_pkg::ADDR_STAT, v);
    chk("stat", 1, v[0]);
    @(posedge clk);
    chk("irq_clr", 0, irq);
  endtask
  // Clearing the counter in time keeps the match away
  task t_kick;
    repeat (6) begin
      repeat (1500) @(posedge clk);
      wr(wdt_pkg::ADDR_CMP, 8'h81);
    end
    rd(wdt_pkg::ADDR_STAT, v);
    chk("kicked", 0, v[0]);
  endtask
  // Reset mode in sub clock: pulse, then oscillator back on
  task t_reset;
    wr(wdt_pkg::ADDR_MASK, 8'h00);
    sub_clock_mode <= 1'b1;
    repeat (8) @(posedge clk);
    chk("osc_sub", 0, main_osc_on);
    wr(wdt_pkg::ADDR_CMP, 8'h81);
    wr(wdt_pkg::ADDR_CTRL, 8'h50);
    n = 0;
    while (wdt_reset_n !== 1'b0 && n < 8000) begin
      @(posedge clk);
      n++;
    end
    chk("rst_time", 1, n >= 4080 && n <= 6160);
    repeat (10) @(posedge clk);
    chk("pulse_w", wdt_pkg::RESET_PULSE_CYC, width);
    chk("pulses", 1, pulses);
    chk("osc_on", 1, main_osc_on);
    sub_clock_mode <= 1'b0;
    t_defaults();
  endtask
  // Stop mode freezes the system path count, release resumes it
  task t_stop;
    wr(wdt_pkg::ADDR_CMP, 8'hFF);
    wr(wdt_pkg::ADDR_CTRL, 8'h40);
    repeat (9000) @(posedge clk);
    stop_mode <= 1'b1;
    repeat (8) @(posedge clk);
    rd(wdt_pkg::ADDR_CNT, a);
    chk("cnt_run", 4, a);
    repeat (5000) @(posedge clk);
    rd(wdt_pkg::ADDR_CNT, v);
    chk("cnt_hold", a, v);
    stop_mode <= 1'b0;
    repeat (2100) @(posedge clk);
    rd(wdt_pkg::ADDR_CNT, v);
    chk("cnt_resume", 5, v);
  endtask
  // RC source keeps timing through stop: 256*cmp+128 ticks
  task t_rc;
    stop_mode <= 1'b1;
    rd(wdt_pkg::ADDR_STAT, v); // drop events of earlier tests
    wr(wdt_pkg::ADDR_MASK, 8'h01);
    wr(wdt_pkg::ADDR_CMP, 8'h81);
    wr(wdt_pkg::ADDR_CTRL, 8'h60);
    wait_irq();
    chk("rc_time", 1, n >= 7600 && n <= 12900);
    stop_mode <= 1'b0;
  endtask
  task wrap_up;
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    t_defaults();
    t_irq();
    t_kick();
    t_reset();
    t_stop();
    t_rc();
    wrap_up();
  end
  // Run needs about 51k cycles; cut a hang well past that
  initial begin
    #400000;
    n_fail++;
    wrap_up();
  end
endmodule
